// ===== shared/i2c_stat_regs.svh
`ifndef I2C_STAT_REGS_SVH
`define I2C_STAT_REGS_SVH

`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_CONTROL 8'h08
`define REG_OWN_ADDR 8'h0C
`define REG_TRANSMIT 8'h10
`define REG_RECEIVE 8'h14

`define ST_ACK 15
`define ST_MASTER_TX_IN_PROGRESS 14
`define ST_BCL 10
`define ST_GC 9
`define ST_TEN 8
`define ST_WRITE_COLLISION_FLAG 7
`define ST_OV 6
`define ST_DA 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_RBF 1
`define ST_TBF 0

`define CTL_TEN_SEL 10
`define CTL_GC_EN 7

`define MASK_IMPL 16'h03FF
`define STATUS_RESET 16'h0000
`define MASK_RESET 10'h000
`define OWN_ADDR_RESET 10'h000
`define GEN_CALL_ADDR 8'h00
`define TEN_BIT_PREFIX 5'h1E
`define BYTE_LAST_BIT 4'h7
`define ACK_BIT 4'h8

`endif

// ===== shared/i2c_stat_pkg.sv
package i2c_stat_pkg;
   typedef enum logic [2:0] {SL_IDLE, SL_ADDR1, SL_ADDR2, SL_DATA, SL_SKIP} slave_state_t;
   typedef logic [15:0] word_t;
   typedef logic [7:0] byte_t;
endpackage

// ===== shared/bus_event_if.sv
`timescale 1ns/1ps
interface bus_event_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic start;
   logic stop;
   modport detector (output scl, output sda, output scl_rise, output start, output stop);
   modport watcher (input scl, input sda, input scl_rise, input start, input stop);
endinterface

// ===== verilog/bus_condition_detect.sv
`timescale 1ns/1ps
module bus_condition_detect (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Raw bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Decoded bus events
   bus_event_if.detector ev
);
   logic [1:0] meta;
   logic [1:0] synced;
   logic [1:0] prev;
   logic [1:0] next_meta;
   logic [1:0] next_synced;
   logic [1:0] next_prev;

   // Index 1 is clock line, index 0 is data line
   always_comb begin
      next_meta = {scl_in, sda_in};
      next_synced = meta;
      next_prev = synced;
   end

   // Idle bus is high, so reset to ones avoids a false start at release
   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= 2'h3;
         synced <= 2'h3;
         prev <= 2'h3;
      end else begin
         meta <= next_meta;
         synced <= next_synced;
         prev <= next_prev;
      end
   end

   assign ev.scl = synced[1];
   assign ev.sda = synced[0];
   assign ev.scl_rise = synced[1] & ~prev[1];
   assign ev.start = synced[1] & prev[1] & prev[0] & ~synced[0];
   assign ev.stop = synced[1] & prev[1] & ~prev[0] & synced[0];
endmodule

// ===== verilog/masked_addr_compare.sv
`timescale 1ns/1ps
module masked_addr_compare #(
   parameter int WIDTH = 7
) (
   // Compared values
   input wire logic [WIDTH-1:0] incoming,
   input wire logic [WIDTH-1:0] own,
   input wire logic [WIDTH-1:0] mask,
   // Result
   output logic match
);
   // A set mask bit removes the position from comparison
   assign match = &(~(incoming ^ own) | mask);
endmodule

// ===== verilog/i2c_status_mask.sv
`timescale 1ns/1ps
`include "i2c_stat_regs.svh"
module i2c_status_mask (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Master engine
   input wire logic master_active,
   input wire logic master_tx_begin,
   input wire logic master_ack_end,
   input wire logic master_sda_release,
   input wire logic module_busy,
   input wire logic tx_done,
   // Transmit and control outputs
   output logic [7:0] transmit_buffer,
   output logic transmit_buffer_full,
   output logic general_call_enable,
   output logic ten_bit_addressing_select,
   output logic general_call_event
);
   bus_event_if ev ();

   bus_condition_detect u_detect (
      .clk(clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev(ev)
   );

   // Status flags
   logic ack_result, master_tx_in_progress, bus_collision_flag, general_call_received;
   logic ten_bit_match, write_collision_flag, receive_overflow_flag, data_not_address;
   logic stop_seen, start_seen, read_not_write, receive_buffer_full;
   logic next_ack, next_master_tx_in_progress, next_bcl, next_gc, next_ten, next_write_collision_flag, next_ov, next_da;
   logic next_stop, next_start, next_rw, next_rbf, next_tbf;

   // Software registers
   logic [9:0] address_mask_bits, own_slave_address;
   logic [9:0] next_mask, next_own;
   logic next_general_call_enable, next_tensel;
   logic [7:0] receive_buffer, next_rcv, next_trn;
   logic [15:0] next_rdata, status_word;

   // Slave receiver
   i2c_stat_pkg::slave_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] receive_shift_register, next_rsr;
   logic next_gc_event;

   logic byte_done;
   i2c_stat_pkg::byte_t rx_byte;
   logic match7, match_hi, match_lo;
   logic rx_attempt, rx_load, collision;
   logic wr_status, wr_transmit, rd_receive;

   assign rx_byte = {receive_shift_register[6:0], ev.sda};
   assign byte_done = ev.scl_rise && bit_cnt == `BYTE_LAST_BIT && state != i2c_stat_pkg::SL_IDLE;
   assign wr_status = reg_write && reg_addr == `REG_STATUS;
   assign wr_transmit = reg_write && reg_addr == `REG_TRANSMIT;
   assign rd_receive = reg_read && reg_addr == `REG_RECEIVE;
   // Only bits the master let float high can lose arbitration
   assign collision = master_active && master_sda_release && ev.scl_rise && !ev.sda;

   masked_addr_compare #(.WIDTH(7)) u_cmp7 (
      .incoming(rx_byte[7:1]),
      .own(own_slave_address[6:0]),
      .mask(address_mask_bits[6:0]),
      .match(match7)
   );

   masked_addr_compare #(.WIDTH(2)) u_cmp_hi (
      .incoming(rx_byte[2:1]),
      .own(own_slave_address[9:8]),
      .mask(address_mask_bits[9:8]),
      .match(match_hi)
   );

   masked_addr_compare #(.WIDTH(8)) u_cmp_lo (
      .incoming(rx_byte),
      .own(own_slave_address[7:0]),
      .mask(address_mask_bits[7:0]),
      .match(match_lo)
   );

   // Slave address and data tracking
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_rsr = receive_shift_register;
      next_gc = general_call_received;
      next_ten = ten_bit_match;
      next_da = data_not_address;
      next_rw = read_not_write;
      next_gc_event = 1'b0;
      rx_attempt = 1'b0;
      if (ev.start) begin
         next_state = i2c_stat_pkg::SL_ADDR1;
         next_bit_cnt = 4'h0;
      end else if (ev.stop) begin
         next_state = i2c_stat_pkg::SL_IDLE;
         next_gc = 1'b0;
         next_ten = 1'b0;
      end else if (ev.scl_rise && state != i2c_stat_pkg::SL_IDLE) begin
         next_rsr = rx_byte;
         next_bit_cnt = (bit_cnt == `ACK_BIT) ? 4'h0 : bit_cnt + 4'h1;
      end
      if (byte_done) begin
         case (state)
            i2c_stat_pkg::SL_ADDR1: begin
               if (general_call_enable && rx_byte == `GEN_CALL_ADDR) begin
                  next_gc = 1'b1;
                  next_gc_event = 1'b1;
                  next_da = 1'b0;
                  next_rw = 1'b0;
                  next_state = i2c_stat_pkg::SL_DATA;
               end else if (ten_bit_addressing_select) begin
                  if (rx_byte[7:3] == `TEN_BIT_PREFIX && match_hi) begin
                     next_rw = rx_byte[0];
                     next_da = 1'b0;
                     if (!rx_byte[0]) begin
                        next_state = i2c_stat_pkg::SL_ADDR2;
                     end else if (ten_bit_match) begin
                        next_state = i2c_stat_pkg::SL_DATA;
                     end else begin
                        next_state = i2c_stat_pkg::SL_SKIP;
                     end
                  end else begin
                     next_state = i2c_stat_pkg::SL_SKIP;
                  end
               end else if (match7) begin
                  next_rw = rx_byte[0];
                  next_da = 1'b0;
                  next_state = i2c_stat_pkg::SL_DATA;
               end else begin
                  next_state = i2c_stat_pkg::SL_SKIP;
               end
            end
            i2c_stat_pkg::SL_ADDR2: begin
               if (match_lo) begin
                  next_ten = 1'b1;
                  next_da = 1'b0;
                  next_state = i2c_stat_pkg::SL_DATA;
               end else begin
                  next_state = i2c_stat_pkg::SL_SKIP;
               end
            end
            i2c_stat_pkg::SL_DATA: begin
               next_da = 1'b1;
               rx_attempt = !read_not_write;
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= i2c_stat_pkg::SL_IDLE;
         bit_cnt <= 4'h0;
         receive_shift_register <= 8'h00;
         general_call_received <= 1'b0;
         ten_bit_match <= 1'b0;
         data_not_address <= 1'b0;
         read_not_write <= 1'b0;
         general_call_event <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         receive_shift_register <= next_rsr;
         general_call_received <= next_gc;
         ten_bit_match <= next_ten;
         data_not_address <= next_da;
         read_not_write <= next_rw;
         general_call_event <= next_gc_event;
      end
   end

   // A full receive buffer keeps its unread byte; the new one is dropped
   assign rx_load = rx_attempt && !receive_buffer_full;

   // Status flags: hardware sets win over software clears in the same cycle
   always_comb begin
      next_ack = master_ack_end ? ev.sda : ack_result;
      next_master_tx_in_progress = master_tx_in_progress;
      if (master_ack_end) next_master_tx_in_progress = 1'b0;
      if (master_tx_begin) next_master_tx_in_progress = 1'b1;
      next_bcl = bus_collision_flag;
      next_write_collision_flag = write_collision_flag;
      next_ov = receive_overflow_flag;
      next_stop = stop_seen;
      next_start = start_seen;
      if (wr_status) begin
         next_bcl = bus_collision_flag & reg_wdata[`ST_BCL];
         next_write_collision_flag = write_collision_flag & reg_wdata[`ST_WRITE_COLLISION_FLAG];
         next_ov = receive_overflow_flag & reg_wdata[`ST_OV];
         next_stop = stop_seen & reg_wdata[`ST_STOP];
         next_start = start_seen & reg_wdata[`ST_START];
      end
      if (collision) next_bcl = 1'b1;
      if (wr_transmit && module_busy) next_write_collision_flag = 1'b1;
      if (rx_attempt && receive_buffer_full) next_ov = 1'b1;
      if (ev.start) begin
         next_start = 1'b1;
         next_stop = 1'b0;
      end else if (ev.stop) begin
         next_start = 1'b0;
         next_stop = 1'b1;
      end
      next_rbf = receive_buffer_full;
      if (rd_receive) next_rbf = 1'b0;
      if (rx_load) next_rbf = 1'b1;
      next_rcv = rx_load ? rx_byte : receive_buffer;
      next_tbf = transmit_buffer_full;
      next_trn = transmit_buffer;
      if (tx_done) next_tbf = 1'b0;
      if (wr_transmit && !module_busy) begin
         next_tbf = 1'b1;
         next_trn = reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_result <= 1'b0;
         master_tx_in_progress <= 1'b0;
         bus_collision_flag <= 1'b0;
         write_collision_flag <= 1'b0;
         receive_overflow_flag <= 1'b0;
         stop_seen <= 1'b0;
         start_seen <= 1'b0;
         receive_buffer_full <= 1'b0;
         receive_buffer <= 8'h00;
         transmit_buffer_full <= 1'b0;
         transmit_buffer <= 8'h00;
      end else begin
         ack_result <= next_ack;
         master_tx_in_progress <= next_master_tx_in_progress;
         bus_collision_flag <= next_bcl;
         write_collision_flag <= next_write_collision_flag;
         receive_overflow_flag <= next_ov;
         stop_seen <= next_stop;
         start_seen <= next_start;
         receive_buffer_full <= next_rbf;
         receive_buffer <= next_rcv;
         transmit_buffer_full <= next_tbf;
         transmit_buffer <= next_trn;
      end
   end

   always_comb begin
      status_word = `STATUS_RESET;
      status_word[`ST_ACK] = ack_result;
      status_word[`ST_MASTER_TX_IN_PROGRESS] = master_tx_in_progress;
      status_word[`ST_BCL] = bus_collision_flag;
      status_word[`ST_GC] = general_call_received;
      status_word[`ST_TEN] = ten_bit_match;
      status_word[`ST_WRITE_COLLISION_FLAG] = write_collision_flag;
      status_word[`ST_OV] = receive_overflow_flag;
      status_word[`ST_DA] = data_not_address;
      status_word[`ST_STOP] = stop_seen;
      status_word[`ST_START] = start_seen;
      status_word[`ST_RW] = read_not_write;
      status_word[`ST_RBF] = receive_buffer_full;
      status_word[`ST_TBF] = transmit_buffer_full;
   end

   // Configuration registers and read port
   always_comb begin
      next_mask = address_mask_bits;
      next_own = own_slave_address;
      next_general_call_enable = general_call_enable;
      next_tensel = ten_bit_addressing_select;
      if (reg_write) begin
         case (reg_addr)
            `REG_MASK: next_mask = reg_wdata[9:0];
            `REG_OWN_ADDR: next_own = reg_wdata[9:0];
            `REG_CONTROL: begin
               next_general_call_enable = reg_wdata[`CTL_GC_EN];
               next_tensel = reg_wdata[`CTL_TEN_SEL];
            end
            default: next_mask = address_mask_bits;
         endcase
      end
      next_rdata = 16'h0000;
      if (reg_read) begin
         case (reg_addr)
            `REG_STATUS: next_rdata = status_word;
            `REG_MASK: next_rdata = {6'h00, address_mask_bits};
            `REG_OWN_ADDR: next_rdata = {6'h00, own_slave_address};
            `REG_CONTROL: begin
               next_rdata[`CTL_GC_EN] = general_call_enable;
               next_rdata[`CTL_TEN_SEL] = ten_bit_addressing_select;
            end
            `REG_TRANSMIT: next_rdata = {8'h00, transmit_buffer};
            `REG_RECEIVE: next_rdata = {8'h00, receive_buffer};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         address_mask_bits <= `MASK_RESET;
         own_slave_address <= `OWN_ADDR_RESET;
         general_call_enable <= 1'b0;
         ten_bit_addressing_select <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         address_mask_bits <= next_mask;
         own_slave_address <= next_own;
         general_call_enable <= next_general_call_enable;
         ten_bit_addressing_select <= next_tensel;
         reg_rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_ack_window;
      master_tx_begin && !master_ack_end ##1 (!master_ack_end)[*2];
   endsequence
   sequence s_write_transmit;
      reg_write && reg_addr == `REG_TRANSMIT;
   endsequence

   a_ack_result_update: assert property (master_ack_end |=> ack_result == $past(ev.sda))
      else $error("ack result not taken from data line");
   a_master_tx_in_progress_held: assert property (s_ack_window |-> master_tx_in_progress)
      else $error("transmit status dropped before acknowledge");
   a_master_tx_in_progress_clear: assert property (master_ack_end && !master_tx_begin |=> !master_tx_in_progress)
      else $error("transmit status not cleared at acknowledge");
   a_bcl_sticky: assert property (bus_collision_flag && !(wr_status && !reg_wdata[`ST_BCL])
      |=> bus_collision_flag)
      else $error("collision flag lost without software clear");
   a_gc_stop_clear: assert property (ev.stop |=> !general_call_received && !ten_bit_match)
      else $error("match flags survive stop");
   a_write_collision_flag_busy: assert property (s_write_transmit and module_busy
      |=> write_collision_flag && $stable(transmit_buffer))
      else $error("busy transmit write not refused");
   a_overflow_set: assert property (rx_attempt && receive_buffer_full
      |=> receive_overflow_flag && $stable(receive_buffer))
      else $error("overflow not flagged");
   a_start_last: assert property (ev.start |=> start_seen && !stop_seen)
      else $error("start condition not recorded");
   a_stop_last: assert property (ev.stop |=> stop_seen && !start_seen)
      else $error("stop condition not recorded");
   a_rbf_cycle: assert property (rx_load |=> receive_buffer_full && receive_buffer == $past(rx_byte))
      else $error("receive full not set on load");
   a_rbf_read_clear: assert property (rd_receive && !rx_load |=> !receive_buffer_full)
      else $error("receive full not cleared by read");
   a_tbf_write: assert property (s_write_transmit and !module_busy
      |=> transmit_buffer_full && transmit_buffer == $past(reg_wdata[7:0]))
      else $error("transmit write not stored");
   a_mask_read_zero: assert property (reg_read && reg_addr == `REG_MASK
      |=> reg_rdata[15:10] == 6'h00 && reg_rdata[9:0] == $past(address_mask_bits))
      else $error("mask read wrong");
endmodule

// ===== test/i2c_far_master.sv
`timescale 1ns/1ps
module i2c_far_master (
   // Bus lines; a released line is driven high by this model, there is no pull-up
   output logic scl,
   output logic sda
);
   localparam time HALF = 40ns;

   // Clock stands still high outside frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic start_cond();
      sda = 1'b1;
      #HALF scl = 1'b1;
      #HALF sda = 1'b0;
      #HALF scl = 1'b0;
   endtask

   task automatic stop_cond();
      sda = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda = 1'b1;
      #HALF;
   endtask

   // Eight bits MSB first, then an acknowledge clock with sda released
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         sda = (i < 0) ? 1'b1 : b[i];
         #HALF scl = 1'b1;
         #HALF scl = 1'b0;
      end
   endtask

   // Holds scl low so sda may change without forming a start or stop
   task automatic park(input logic v);
      scl = 1'b0;
      #HALF sda = v;
      #HALF;
   endtask

   task automatic idle();
      sda = 1'b1;
      #HALF scl = 1'b1;
      #HALF;
   endtask
endmodule

// ===== test/i2c_status_and_address_mask_tb.sv
`timescale 1ns/1ps
`include "i2c_stat_regs.svh"
module i2c_status_and_address_mask_tb;
   logic clk;
   logic reset;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic master_active;
   logic master_tx_begin;
   logic master_ack_end;
   logic master_sda_release;
   logic module_busy;
   logic tx_done;
   logic [15:0] reg_rdata;
   logic [7:0] transmit_buffer;
   logic transmit_buffer_full;
   logic general_call_enable;
   logic ten_bit_addressing_select;
   logic general_call_event;
   wire scl;
   wire sda;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int gc_cnt = 0;

   i2c_status_mask i2c_status_mask_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda),
      .master_active(master_active), .master_tx_begin(master_tx_begin), .master_ack_end(master_ack_end),
      .master_sda_release(master_sda_release), .module_busy(module_busy), .tx_done(tx_done),
      .transmit_buffer(transmit_buffer), .transmit_buffer_full(transmit_buffer_full),
      .general_call_enable(general_call_enable), .ten_bit_addressing_select(ten_bit_addressing_select),
      .general_call_event(general_call_event));
   i2c_far_master i2c_far_master_inst (.scl(scl), .sda(sda));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // A hang is cut short long after the longest expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (general_call_event === 1'b1)
         gc_cnt <= gc_cnt + 1;
      if (cycles == 30000) begin
         err_count++;
         conclude();
      end
   end

   task automatic conclude();
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, reg_rdata & m);
   endtask

   task automatic strobe(input int k);
      @(posedge clk);
      master_tx_begin <= (k == 0);
      master_ack_end <= (k == 1);
      tx_done <= (k == 2);
      @(posedge clk);
      master_tx_begin <= 1'b0;
      master_ack_end <= 1'b0;
      tx_done <= 1'b0;
   endtask

   task automatic t_regs();
      rd(`REG_STATUS, 16'hFFFF, `STATUS_RESET);
      wr(`REG_MASK, 16'hFFFF);
      rd(`REG_MASK, 16'hFFFF, 16'h03FF);
      wr(`REG_STATUS, 16'hFFFF);
      rd(`REG_STATUS, 16'hFFFF, 16'h0000);
      rd(8'h20, 16'hFFFF, 16'h0000);
      wr(`REG_MASK, 16'h0000);
   endtask

   task automatic t_master();
      i2c_far_master_inst.park(1'b0);
      strobe(0);
      rd(`REG_STATUS, 16'hC000, 16'h4000);
      strobe(1);
      rd(`REG_STATUS, 16'hC000, 16'h0000);
      i2c_far_master_inst.park(1'b1);
      strobe(0);
      strobe(1);
      rd(`REG_STATUS, 16'hC000, 16'h8000);
      i2c_far_master_inst.idle();
   endtask

   task automatic t_collide();
      i2c_far_master_inst.park(1'b0);
      @(posedge clk);
      master_active <= 1'b1;
      master_sda_release <= 1'b1;
      i2c_far_master_inst.send_byte(8'h00);
      @(posedge clk);
      master_active <= 1'b0;
      master_sda_release <= 1'b0;
      i2c_far_master_inst.idle();
      wr(`REG_STATUS, 16'hFFFF);
      rd(`REG_STATUS, 16'h0400, 16'h0400);
      wr(`REG_STATUS, 16'hFBFF);
      rd(`REG_STATUS, 16'h0400, 16'h0000);
   endtask

   task automatic t_txbuf();
      @(posedge clk);
      module_busy <= 1'b1;
      wr(`REG_TRANSMIT, 16'h005A);
      rd(`REG_STATUS, 16'h0081, 16'h0080);
      rd(`REG_TRANSMIT, 16'h00FF, 16'h0000);
      module_busy <= 1'b0;
      wr(`REG_TRANSMIT, 16'h00A5);
      rd(`REG_STATUS, 16'h0081, 16'h0081);
      chk("transmit_buffer", 16'h01A5, {7'h00, transmit_buffer_full, transmit_buffer});
      strobe(2);
      rd(`REG_STATUS, 16'h0081, 16'h0080);
      wr(`REG_STATUS, 16'hFF7F);
      rd(`REG_STATUS, 16'h0080, 16'h0000);
   endtask

   task automatic t_slave();
      wr(`REG_OWN_ADDR, 16'h002A);
      i2c_far_master_inst.start_cond();
      rd(`REG_STATUS, 16'h0018, 16'h0008);
      i2c_far_master_inst.send_byte(8'h54);
      rd(`REG_STATUS, 16'h0024, 16'h0000);
      i2c_far_master_inst.send_byte(8'h3C);
      rd(`REG_STATUS, 16'h0062, 16'h0022);
      i2c_far_master_inst.send_byte(8'hC3);
      rd(`REG_STATUS, 16'h0042, 16'h0042);
      rd(`REG_RECEIVE, 16'h00FF, 16'h003C);
      rd(`REG_STATUS, 16'h0002, 16'h0000);
      wr(`REG_STATUS, 16'hFFBF);
      rd(`REG_STATUS, 16'h0040, 16'h0000);
      i2c_far_master_inst.start_cond();
      i2c_far_master_inst.send_byte(8'h55);
      rd(`REG_STATUS, 16'h003C, 16'h000C);
      i2c_far_master_inst.stop_cond();
      rd(`REG_STATUS, 16'h0018, 16'h0010);
   endtask

   // Address 0x2B only reaches the 0x2A slave when bit 0 is masked
   task automatic t_mask();
      for (int m = 0; m < 2; m++) begin
         wr(`REG_MASK, 16'(m));
         i2c_far_master_inst.start_cond();
         i2c_far_master_inst.send_byte(8'h56);
         i2c_far_master_inst.send_byte(8'h11);
         rd(`REG_STATUS, 16'h0002, 16'(m << 1));
         rd(`REG_RECEIVE, 16'h00FF, m ? 16'h0011 : 16'h003C);
         i2c_far_master_inst.stop_cond();
      end
      wr(`REG_MASK, 16'h0000);
   endtask

   task automatic t_gcall();
      for (int en = 1; en >= 0; en--) begin
         wr(`REG_CONTROL, 16'(en << 7));
         rd(`REG_CONTROL, 16'h0480, 16'(en << 7));
         chk("gc_enable", 16'(en), {15'h0000, general_call_enable});
         i2c_far_master_inst.start_cond();
         i2c_far_master_inst.send_byte(`GEN_CALL_ADDR);
         rd(`REG_STATUS, 16'h0200, 16'(en << 9));
         chk("gc_event", 16'h0001, 16'(gc_cnt));
         i2c_far_master_inst.stop_cond();
         rd(`REG_STATUS, 16'h0200, 16'h0000);
      end
   endtask

   task automatic t_ten();
      wr(`REG_OWN_ADDR, 16'h02A5);
      for (int sel = 1; sel >= 0; sel--) begin
         wr(`REG_CONTROL, 16'(sel << 10));
         #1 chk("ten_bit_select", 16'(sel), {15'h0000, ten_bit_addressing_select});
         i2c_far_master_inst.start_cond();
         i2c_far_master_inst.send_byte(8'hF4);
         i2c_far_master_inst.send_byte(8'hA5);
         rd(`REG_STATUS, 16'h0100, 16'(sel << 8));
         i2c_far_master_inst.stop_cond();
         rd(`REG_STATUS, 16'h0100, 16'h0000);
      end
   endtask

   initial begin
      reset <= 1'b1;
      reg_addr <= 8'h00;
      reg_wdata <= 16'h0000;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      master_active <= 1'b0;
      master_tx_begin <= 1'b0;
      master_ack_end <= 1'b0;
      master_sda_release <= 1'b0;
      module_busy <= 1'b0;
      tx_done <= 1'b0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_master();
      t_collide();
      t_txbuf();
      t_slave();
      t_mask();
      t_gcall();
      t_ten();
      conclude();
   end
endmodule
